// *** core/adcseq_top.sv ***
// Conversion sequencer: AXI4-Lite registers, prescaler, sample/convert phases, interrupt
//
// Notes on behaviour
// (R1) Start launches on a high-then-low pulse
// (R2) Hardware sets busy once launched
// (R3) Hardware clears busy on completion
// (R4) Completion sets flag; enabled flag raises interrupt
// (R5) Software may poll busy instead
// (R6) Divider select gives divide by 1 to 128
// (R7) Software keeps conversion clock within limits
// (R8) Power enable gates converter circuitry
// (R9) Software waits settling before starting
// (R10) Software clears power when idle
// (R11) Sampling lasts exactly 4 conversion clocks
// (R12) Conversion 12 clocks, total 16
// (R13) Conversion runs without stalling the processor
// (R14) 12-bit result as high and low bytes
// (R15) Result valid once busy drops
// (R16) Start during conversion restarts sampling, busy kept
// (R17) Power clear aborts, no interrupt flag
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
`include "adcseq_defines.svh"

module adcseq_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              CLK_IN,
    input  wire logic              RST_N_IN,
    input  wire logic              AXI_AWVALID_IN,
    output logic                   AXI_AWREADY_OUT,
    input  wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
    input  wire logic              AXI_WVALID_IN,
    output logic                   AXI_WREADY_OUT,
    input  wire logic [31:0]       AXI_WDATA_IN,
    input  wire logic [3:0]        AXI_WSTRB_IN,
    output logic                   AXI_BVALID_OUT,
    input  wire logic              AXI_BREADY_IN,
    output logic      [1:0]        AXI_BRESP_OUT,
    input  wire logic              AXI_ARVALID_IN,
    output logic                   AXI_ARREADY_OUT,
    input  wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
    output logic                   AXI_RVALID_OUT,
    input  wire logic              AXI_RREADY_IN,
    output logic      [31:0]       AXI_RDATA_OUT,
    output logic      [1:0]        AXI_RRESP_OUT,
    input  wire logic [11:0]       CORE_RESULT_IN,
    output logic                   CORE_POWER_OUT,
    output logic                   CORE_SAMPLE_OUT,
    output logic                   CORE_CONVERT_OUT,
    output logic                   CORE_CLK_OUT,
    output logic                   IRQ_OUT
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    adcseq_pkg::adcseq_ctrl_t  ctrl;
    adcseq_pkg::adcseq_state_t state;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wr_fire;
    logic              wr_lo;
    logic [31:0]       next_rdata;
    logic              start_d;
    logic              launch;
    logic              tick;
    logic              done;
    logic              busy;
    logic [4:0]        tick_cnt;
    logic [2:0]        div_lat;
    logic [11:0]       result;
    logic [0:0]        int_status;
    logic [0:0]        int_mask;

    // Byte address match against one of the registers
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == ADDR_W'(`ADCSEQ_OFS_CTRL0))    ||
                    (a == ADDR_W'(`ADCSEQ_OFS_CTRL1))    ||
                    (a == ADDR_W'(`ADCSEQ_OFS_RES_HI))   ||
                    (a == ADDR_W'(`ADCSEQ_OFS_RES_LO))   ||
                    (a == ADDR_W'(`ADCSEQ_OFS_INT_STAT)) ||
                    (a == ADDR_W'(`ADCSEQ_OFS_INT_MASK));
    endfunction

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------

    // Address and data are caught in either order; both stall while a response waits
    assign AXI_AWREADY_OUT = !aw_got && !AXI_BVALID_OUT;
    assign AXI_WREADY_OUT  = !w_got && !AXI_BVALID_OUT;
    assign wr_fire         = aw_got && w_got;
    assign wr_lo           = wr_fire && w_strb[0]; // Only the low lane holds bits

    // Write address holding register
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            aw_got  <= 1'b0;
            aw_addr <= '0;
        end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
            aw_got  <= 1'b1;
            aw_addr <= AXI_AWADDR_IN;
        end else if (wr_fire) begin
            aw_got  <= 1'b0;
        end
    end

    // Write data holding register
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            w_got  <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
            w_got  <= 1'b1;
            w_data <= AXI_WDATA_IN;
            w_strb <= AXI_WSTRB_IN;
        end else if (wr_fire) begin
            w_got  <= 1'b0;
        end
    end

    // Response one cycle after both halves are held; unmapped answers SLVERR
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            AXI_BVALID_OUT <= 1'b0;
            AXI_BRESP_OUT  <= `ADCSEQ_RESP_OKAY;
        end else if (wr_fire) begin
            AXI_BVALID_OUT <= 1'b1;
            AXI_BRESP_OUT  <= is_mapped(aw_addr) ? `ADCSEQ_RESP_OKAY : `ADCSEQ_RESP_SLVERR;
        end else if (AXI_BREADY_IN) begin
            AXI_BVALID_OUT <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------

    // Start, power and divider select; the select only takes effect at the next launch
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ctrl <= '{div_sel: `ADCSEQ_RST_DIV_SEL, power: 1'b0, start: 1'b0};
        end else if (wr_lo && aw_addr == ADDR_W'(`ADCSEQ_OFS_CTRL0)) begin
            ctrl.start <= w_data[`ADCSEQ_BIT_START];
            ctrl.power <= w_data[`ADCSEQ_BIT_POWER];
        end else if (wr_lo && aw_addr == ADDR_W'(`ADCSEQ_OFS_CTRL1)) begin
            ctrl.div_sel <= w_data[2:0];
        end
    end

    // Previous start level, to see the falling half of the pulse
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            start_d <= 1'b0;
        end else begin
            start_d <= ctrl.start;
        end
    end

    // Launch only on the fall that closes a high pulse, and only when powered
    assign launch = start_d && !ctrl.start && ctrl.power; // R1 R8

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------

    // Read data selection; unused bits read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (AXI_ARADDR_IN)
            ADDR_W'(`ADCSEQ_OFS_CTRL0): begin
                next_rdata[`ADCSEQ_BIT_START] = ctrl.start;
                next_rdata[`ADCSEQ_BIT_POWER] = ctrl.power;
                next_rdata[`ADCSEQ_BIT_BUSY]  = busy; // R5
            end
            ADDR_W'(`ADCSEQ_OFS_CTRL1): begin
                next_rdata[2:0] = ctrl.div_sel;
            end
            ADDR_W'(`ADCSEQ_OFS_RES_HI): begin
                next_rdata[3:0] = result[11:8]; // R14
            end
            ADDR_W'(`ADCSEQ_OFS_RES_LO): begin
                next_rdata[7:0] = result[7:0]; // R14
            end
            ADDR_W'(`ADCSEQ_OFS_INT_STAT): begin
                next_rdata[0] = int_status[0];
            end
            ADDR_W'(`ADCSEQ_OFS_INT_MASK): begin
                next_rdata[0] = int_mask[0];
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // One read at a time; address is refused while data waits
    assign AXI_ARREADY_OUT = !AXI_RVALID_OUT;

    // Registered read answer one cycle after the address is taken
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            AXI_RVALID_OUT <= 1'b0;
            AXI_RDATA_OUT  <= 32'h0000_0000;
            AXI_RRESP_OUT  <= `ADCSEQ_RESP_OKAY;
        end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
            AXI_RVALID_OUT <= 1'b1;
            AXI_RDATA_OUT  <= next_rdata;
            AXI_RRESP_OUT  <= is_mapped(AXI_ARADDR_IN) ? `ADCSEQ_RESP_OKAY
                                                       : `ADCSEQ_RESP_SLVERR;
        end else if (AXI_RREADY_IN) begin
            AXI_RVALID_OUT <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------

    // Prescaler restarts at every launch, so each conversion has exact length
    adcseq_prescaler u_presc (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .clear_in (launch),
        .run_in   (busy),
        .sel_in   (div_lat),
        .tick_out (tick)
    );

    // Last tick of the conversion phase marks completion; a power clear landing
    // in that very cycle is an abort, so it must not raise the flag
    assign done = (state == adcseq_pkg::ST_CONVERT) && tick && ctrl.power && // R17
                  (tick_cnt == `ADCSEQ_TOTAL_TICKS - 5'h01); // R12

    // Phase register; power loss wins over everything, a relaunch restarts sampling
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || !ctrl.power) begin
            state <= adcseq_pkg::ST_IDLE; // R17
        end else if (launch) begin
            state <= adcseq_pkg::ST_SAMPLE; // R16
        end else begin
            case (state)
                adcseq_pkg::ST_SAMPLE: begin
                    if (tick && tick_cnt == `ADCSEQ_SAMPLE_TICKS - 5'h01) begin
                        state <= adcseq_pkg::ST_CONVERT; // R11
                    end
                end
                adcseq_pkg::ST_CONVERT: begin
                    if (done) begin
                        state <= adcseq_pkg::ST_IDLE; // R12
                    end
                end
                default: begin
                    state <= adcseq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Conversion clock count since launch
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || launch) begin
            tick_cnt <= 5'h00;
        end else if (tick) begin
            tick_cnt <= tick_cnt + 5'h01; // R11 R12
        end
    end

    // Busy flag is hardware owned; software never writes it
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || !ctrl.power) begin
            busy <= 1'b0; // R17
        end else if (launch) begin
            busy <= 1'b1; // R2 R16
        end else if (done) begin
            busy <= 1'b0; // R3
        end
    end

    // Divider latched at launch; result captured as busy drops
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            div_lat <= `ADCSEQ_RST_DIV_SEL;
            result  <= 12'h000;
        end else begin
            if (launch) begin
                div_lat <= ctrl.div_sel; // R6
            end
            if (done) begin
                result <= CORE_RESULT_IN; // R14 R15
            end
        end
    end

    // Core control; the bus never waits on the sequencer
    assign CORE_POWER_OUT   = ctrl.power; // R8
    assign CORE_SAMPLE_OUT  = (state == adcseq_pkg::ST_SAMPLE);
    assign CORE_CONVERT_OUT = (state == adcseq_pkg::ST_CONVERT); // R13
    assign CORE_CLK_OUT     = tick;

    // ----------------------------------------------------------------
    // Interrupt flags
    // ----------------------------------------------------------------

    adcseq_irq #(
        .NUM_EVT (1)
    ) u_irq (
        .clk_in      (CLK_IN),
        .rst_n_in    (RST_N_IN),
        .event_in    (done),
        .clear_we_in (wr_lo && aw_addr == ADDR_W'(`ADCSEQ_OFS_INT_STAT)),
        .mask_we_in  (wr_lo && aw_addr == ADDR_W'(`ADCSEQ_OFS_INT_MASK)),
        .wdata_in    (w_data[`ADCSEQ_BIT_DONE]),
        .status_out  (int_status),
        .mask_out    (int_mask),
        .irq_out     (IRQ_OUT)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    // Cycles since launch, only for the checks below
    logic [12:0] cyc;
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || launch) begin
            cyc <= 13'h0001;
        end else if (busy) begin
            cyc <= cyc + 13'h0001;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_launch_pulse: assert property (launch |-> $past(ctrl.start) && !ctrl.start) // R1
        else $error("launch without a start pulse");
    a_busy_raise: assert property (launch |=> busy ##0 state == adcseq_pkg::ST_SAMPLE) // R2
        else $error("busy not raised after launch");
    a_busy_clear: assert property (done && !launch |=> !busy ##0 int_status[0]) // R3
        else $error("busy or flag wrong after done");
    a_irq_raise: assert property (done && int_mask[0] |=> IRQ_OUT) // R4
        else $error("enabled interrupt not raised");
    a_div_length: assert property (done |-> cyc == (13'h0010 << div_lat)) // R6
        else $error("conversion length not sixteen divided clocks");
    a_sample_len: assert property (state == adcseq_pkg::ST_SAMPLE ##1
                                   state == adcseq_pkg::ST_CONVERT
                                   |-> cyc == (13'h0004 << div_lat) + 13'h0001) // R11
        else $error("sampling phase not four divided clocks");
    a_power_gate: assert property (!ctrl.power |=> !busy && !CORE_SAMPLE_OUT
                                   && !CORE_CONVERT_OUT) // R8
        else $error("converter active while unpowered");
    a_restart_busy: assert property (launch && busy |=> busy ##0 tick_cnt == 5'h00) // R16
        else $error("restart lost busy");
    a_abort_noflag: assert property (busy && !ctrl.power && !int_status[0]
                                     |=> !busy ##0 !int_status[0]) // R17
        else $error("abort set the interrupt flag");
    a_result_held: assert property (done |=> result == $past(CORE_RESULT_IN) // R15
                                    ##1 $stable(result))
        else $error("result not captured or not held after completion");

    c_full_conv: cover property (launch ##[1:300] done);
    c_restart:   cover property (launch && busy);
    c_abort:     cover property (busy && !ctrl.power);
    c_irq:       cover property ($rose(IRQ_OUT));

endmodule // adcseq_top

`default_nettype wire

// *** include/adcseq_defines.svh ***
// Register map, field positions, reset values and timing counts of the conversion sequencer
`ifndef ADCSEQ_DEFINES_SVH
`define ADCSEQ_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADCSEQ_OFS_CTRL0      8'h00
`define ADCSEQ_OFS_CTRL1      8'h04
`define ADCSEQ_OFS_RES_HI     8'h08
`define ADCSEQ_OFS_RES_LO     8'h0c
`define ADCSEQ_OFS_INT_STAT   8'h10
`define ADCSEQ_OFS_INT_MASK   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCSEQ_BIT_START      0
`define ADCSEQ_BIT_POWER      1
`define ADCSEQ_BIT_BUSY       2
`define ADCSEQ_BIT_DONE       0

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define ADCSEQ_RST_DIV_SEL    3'h0
`define ADCSEQ_RST_MASK       1'h0
`define ADCSEQ_RESP_OKAY      2'h0
`define ADCSEQ_RESP_SLVERR    2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCSEQ_CLK_PERIOD_NS  50
`define ADCSEQ_SAMPLE_TICKS   5'h04
`define ADCSEQ_CONV_TICKS     5'h0c
`define ADCSEQ_TOTAL_TICKS    (`ADCSEQ_SAMPLE_TICKS + `ADCSEQ_CONV_TICKS)

`endif

// *** include/adcseq_pkg.sv ***
// Types shared by the conversion sequencer modules
`default_nettype none

package adcseq_pkg;

    // Sequencer phases
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } adcseq_state_t;

    // Software control bits
    typedef struct packed {
        logic [2:0] div_sel;
        logic       power;
        logic       start;
    } adcseq_ctrl_t;

endpackage

`default_nettype wire

// *** core/adcseq_prescaler.sv ***
// Conversion clock prescaler: one tick every 2**sel system clocks
`default_nettype none

module adcseq_prescaler (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       clear_in,
    input  wire logic       run_in,
    input  wire logic [2:0] sel_in,
    output logic            tick_out
);

    logic [6:0] cnt;
    logic [7:0] last;

    // Ratio doubles with each step of the select
    assign last     = 8'((9'h001 << sel_in) - 9'h001); // R6
    assign tick_out = run_in && ({1'b0, cnt} == last);  // R6

    // Cleared at launch so the first tick lands a whole period later
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in || !run_in) begin
            cnt <= 7'h00;
        end else if (tick_out) begin
            cnt <= 7'h00;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end

endmodule // adcseq_prescaler

`default_nettype wire

// *** core/adcseq_irq.sv ***
// Sticky event flags with write-one-to-clear, a mask and one level interrupt
`default_nettype none
`include "adcseq_defines.svh"

module adcseq_irq #(
    parameter int NUM_EVT = 1
) (
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic [NUM_EVT-1:0] event_in,
    input  wire logic               clear_we_in,
    input  wire logic               mask_we_in,
    input  wire logic [NUM_EVT-1:0] wdata_in,
    output logic      [NUM_EVT-1:0] status_out,
    output logic      [NUM_EVT-1:0] mask_out,
    output logic                    irq_out
);

    // One sticky flag per event; a set in the clearing cycle wins
    for (genvar i = 0; i < NUM_EVT; i++) begin : g_flag
        always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
                status_out[i] <= 1'b0;
                mask_out[i]   <= `ADCSEQ_RST_MASK;
            end else begin
                if (event_in[i]) begin
                    status_out[i] <= 1'b1; // R4
                end else if (clear_we_in && wdata_in[i]) begin
                    status_out[i] <= 1'b0;
                end
                if (mask_we_in) begin
                    mask_out[i] <= wdata_in[i];
                end
            end
        end
    end

    // Level request while any unmasked flag stands
    assign irq_out = |(status_out & mask_out); // R4

endmodule // adcseq_irq

`default_nettype wire

// *** tb/adcseq_core_model.sv ***
// Behavioural converter core facing the sequencer's core port
`default_nettype none

module adcseq_core_model (
    input  wire logic        clk_in,
    input  wire logic        power_in,
    input  wire logic        convert_in,
    input  wire logic [11:0] code_in,
    output logic      [11:0] result_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Result path
    // ------------------------------------------------------------
    // Outside a powered conversion the result is the inverse of the code,
    // so a capture taken at the wrong moment cannot pass for a match
    always_ff @(posedge clk_in) begin
        result_out <= (power_in & convert_in) ? code_in : ~code_in;
    end
endmodule  // adcseq_core_model

`default_nettype wire

// *** tb/adcseq_top_tb.sv ***
// Self-checking bench for the conversion sequencer over its register bus
`default_nettype none

module adcseq_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int LIMIT = 20000;  // Full divider sweep needs about 4300 cycles
    logic        clk, rst_n, aw_v, w_v, b_r, ar_v, r_r, clr;
    logic [7:0]  aw_a, ar_a;
    logic [31:0] w_d, rdata, v;
    logic [11:0] code, res;
    logic        awrdy, wrdy, bv, arrdy, rv, pwr, sam, cnv, tck, irq;
    logic [1:0]  bresp, rresp;
    int          n_s, n_c, n_k, cyc = 0, fail_count = 0, comparisons = 0;

    adcseq_top dut (
        .CLK_IN(clk), .RST_N_IN(rst_n),
        .AXI_AWVALID_IN(aw_v), .AXI_AWREADY_OUT(awrdy), .AXI_AWADDR_IN(aw_a),
        .AXI_WVALID_IN(w_v), .AXI_WREADY_OUT(wrdy), .AXI_WDATA_IN(w_d),
        .AXI_WSTRB_IN(4'hf), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(b_r),
        .AXI_BRESP_OUT(bresp), .AXI_ARVALID_IN(ar_v), .AXI_ARREADY_OUT(arrdy),
        .AXI_ARADDR_IN(ar_a), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(r_r),
        .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .CORE_RESULT_IN(res),
        .CORE_POWER_OUT(pwr), .CORE_SAMPLE_OUT(sam), .CORE_CONVERT_OUT(cnv),
        .CORE_CLK_OUT(tck), .IRQ_OUT(irq)
    );

    adcseq_core_model core (
        .clk_in(clk), .power_in(pwr), .convert_in(cnv), .code_in(code), .result_out(res)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Phase and tick counters; the guard cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_s <= clr ? 0 : n_s + int'(sam);
        n_c <= clr ? 0 : n_c + int'(cnv);
        n_k <= clr ? 0 : n_k + int'(tck);
        if (cyc == LIMIT) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Ready levels are read mid-cycle, where they equal what the next edge sees
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ta, tw, done;
        done = 1'b0;
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        while (!done) begin
            @(negedge clk);
            ta = aw_v & awrdy;
            tw = w_v & wrdy;
            done = bv;
            if (done) chk("bresp", {30'h0, bresp}, {30'h0, e});
            @(posedge clk);
            if (ta) aw_v <= 1'b0;
            if (tw) w_v <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
        logic ta, done;
        logic [1:0] r;
        done = 1'b0;
        ar_a <= a;
        ar_v <= 1'b1;
        while (!done) begin
            @(negedge clk);
            ta = ar_v & arrdy;
            done = rv;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) ar_v <= 1'b0;
        end
        chk("rresp", {30'h0, r}, {30'h0, e});
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        rd(a, d, 2'h0);
        chk(nm, d, e);
    endtask

    task automatic zero();
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask

    task automatic poll();
        logic [31:0] d;
        d = 32'h4;
        while (d[2]) rd(8'h00, d, 2'h0);
    endtask

    // Start pulse is a write of one then zero with power kept on
    task automatic conv(input logic [2:0] s);
        zero();
        wr(8'h04, {29'h0, s}, 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        if (s == 3'h0) begin
            repeat (6) @(posedge clk);
            rc(8'h00, 32'h3, "armed only");
        end
        wr(8'h00, 32'h2, 2'h0);
        rc(8'h00, 32'h6, "busy set");
        poll();
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, aw_v, w_v, ar_v, clr, aw_a, ar_a, w_d, code} = '0;
        {b_r, r_r} = 2'b11;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(8'h00, 32'h0, "ctrl0 reset");
        rc(8'h04, 32'h0, "ctrl1 reset");
        rc(8'h10, 32'h0, "status reset");
        rc(8'h14, 32'h0, "mask reset");
        rd(8'h18, v, 2'h2);
        chk("unmapped data", v, 32'h0);
        wr(8'h18, 32'hffffffff, 2'h2);
        wr(8'h00, 32'h1, 2'h0);
        wr(8'h00, 32'h0, 2'h0);
        repeat (4) @(posedge clk);
        rc(8'h00, 32'h0, "start unpowered");
        chk("power off", {31'h0, pwr}, 32'h0);
        wr(8'h00, 32'h2, 2'h0);
        repeat (20) @(posedge clk);
        chk("power on", {31'h0, pwr}, 32'h1);
        // Low settings run the converter clock faster than it should; fine here
        for (int s = 0; s < 8; s++) begin
            code <= 12'hfff >> s;
            conv(s[2:0]);
            chk("sample cycles", n_s, 32'(4 << s));
            chk("convert cycles", n_c, 32'(12 << s));
            chk("conv clocks", n_k, 32'd16);
            rc(8'h08, {28'h0, code[11:8]}, "result high");
            rc(8'h0c, {24'h0, code[7:0]}, "result low");
            rc(8'h10, 32'h1, "done flag");
            chk("irq level", {31'h0, irq}, {31'h0, s != 0});
            if (s == 0) begin
                wr(8'h14, 32'h1, 2'h0);
                chk("irq unmasked", {31'h0, irq}, 32'h1);
            end
            wr(8'h10, 32'h1, 2'h0);
            chk("irq cleared", {31'h0, irq}, 32'h0);
        end
        zero();
        wr(8'h04, 32'h1, 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        wr(8'h00, 32'h2, 2'h0);
        repeat (12) @(posedge clk);
        wr(8'h00, 32'h3, 2'h0);
        wr(8'h00, 32'h2, 2'h0);
        rc(8'h00, 32'h6, "busy kept");
        poll();
        chk("resampled", n_s, 32'd16);
        wr(8'h10, 32'h1, 2'h0);
        wr(8'h04, 32'h3, 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        wr(8'h00, 32'h2, 2'h0);
        repeat (20) @(posedge clk);
        wr(8'h00, 32'h0, 2'h0);
        zero();
        repeat (120) @(posedge clk);  // Past the point where an unaborted run would end
        chk("phases stopped", 32'(n_s + n_c), 32'd0);
        rc(8'h00, 32'h0, "abort busy");
        rc(8'h10, 32'h0, "abort flag");
        chk("abort irq", {31'h0, irq}, 32'h0);
        tally_and_finish();
    end
endmodule  // adcseq_top_tb

`default_nettype wire
